// file: common/ibs_cond_if.sv
// Carrier for bus condition events between the detector and the flag block.
// Assumes both ends run on the same clock; every event is a one-cycle pulse.
`timescale 1ns/1ps
interface ibs_cond_if;
    logic start_seen;
    logic stop_seen;
    logic bus_active;

    modport det (output start_seen, output stop_seen, output bus_active);
    modport flags (input start_seen, input stop_seen, input bus_active);
endinterface : ibs_cond_if

// file: common/ibs_pkg.sv
// Constants shared by the bus state flag block and its bus condition detector.
// Assumes a 40 MHz clock and a classic Wishbone register port with 32-bit data.
package ibs_pkg;

    // =========================================================================
    // Register byte offsets
    localparam logic [7:0] STAT_OFS = 8'h00;
    localparam logic [7:0] RXHOLD_OFS = 8'h04;
    localparam logic [7:0] TXHOLD_OFS = 8'h08;
    localparam logic [7:0] CTRL_OFS = 8'h0C;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h10;
    localparam logic [7:0] IRQ_CLR_OFS = 8'h14;
    localparam logic [7:0] IRQ_EN_OFS = 8'h18;

    // =========================================================================
    // Status register field positions
    localparam int TXFULL_BIT = 0;
    localparam int RXFULL_BIT = 1;
    localparam int RW_BIT = 2;
    localparam int START_BIT = 3;
    localparam int STOP_BIT = 4;
    localparam int DA_BIT = 5;
    localparam int OVF_BIT = 6;
    localparam int WCOL_BIT = 7;

    // Control register field positions
    localparam int ON_BIT = 0;

    // =========================================================================
    // Interrupt event positions
    localparam int EV_START = 0;
    localparam int EV_STOP = 1;
    localparam int EV_RXFULL = 2;
    localparam int EV_OVF = 3;
    localparam int EV_WCOL = 4;
    localparam int EV_TXDONE = 5;
    localparam int EV_NUM = 6;

    // =========================================================================
    // Reset values
    localparam logic [7:0] STAT_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [5:0] IRQ_RST = 6'h00;
    localparam logic [1:0] SYNC_RST = 2'h3;

endpackage : ibs_pkg

// file: hw/ibs_cond_det.sv
// Start, repeated start and stop detector on the serial clock and data pins.
// Assumes pins are asynchronous to clk_i; they pass two flip-flops first.
`timescale 1ns/1ps
module ibs_cond_det (
    input wire logic clk_i,     // 40 MHz clock
    input wire logic rst_i,     // Synchronous reset, active high
    input wire logic scl_i,     // Serial clock pin level
    input wire logic sda_i,     // Serial data pin level
    ibs_cond_if.det cond        // Condition events out
);

    typedef enum logic [1:0] {
        IBS_IDLE = 2'b01,
        IBS_ACTIVE = 2'b10
    } ibs_bus_type;

    logic [1:0] scl_sync_q;
    logic [1:0] sda_sync_q;
    logic scl_q;
    logic sda_q;
    logic start_w;
    logic stop_w;
    ibs_bus_type state_q;

    // =========================================================================
    // Synchronisers; only the second stage and its one-cycle delayed copy feed any logic
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scl_sync_q <= ibs_pkg::SYNC_RST;
            sda_sync_q <= ibs_pkg::SYNC_RST;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[0], scl_i};
            sda_sync_q <= {sda_sync_q[0], sda_i};
            scl_q <= scl_sync_q[1];
            sda_q <= sda_sync_q[1];
        end
    end

    // Data moving while the clock is high marks a bus condition
    assign start_w = scl_q && scl_sync_q[1] && sda_q && !sda_sync_q[1];
    assign stop_w = scl_q && scl_sync_q[1] && !sda_q && sda_sync_q[1];

    // =========================================================================
    // Event pulses and bus activity
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cond.start_seen <= 1'b0;
            cond.stop_seen <= 1'b0;
        end else begin
            cond.start_seen <= start_w;
            cond.stop_seen <= stop_w;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= IBS_IDLE;
        end else begin
            case (state_q)
                IBS_IDLE: state_q <= start_w ? IBS_ACTIVE : IBS_IDLE;
                IBS_ACTIVE: state_q <= stop_w ? IBS_IDLE : IBS_ACTIVE;
                default: state_q <= IBS_IDLE;
            endcase
        end
    end

    assign cond.bus_active = (state_q == IBS_ACTIVE);

endmodule : ibs_cond_det

// file: hw/ibs_flags.sv
// Bus state flags of a serial two-wire module, with holding registers,
// a Wishbone classic register port and one level interrupt.
// Assumes the receive and transmit shifters and the address match logic
// run on clk_i and present one-cycle event pulses.
`timescale 1ns/1ps
module ibs_flags (
    input wire logic clk_i,                // 40 MHz clock
    input wire logic rst_i,                // Synchronous reset, active high
    input wire logic wb_cyc_i,             // Wishbone cycle
    input wire logic wb_stb_i,             // Wishbone strobe
    input wire logic wb_we_i,              // Wishbone write enable
    input wire logic [7:0] wb_adr_i,       // Wishbone byte address
    input wire logic [3:0] wb_sel_i,       // Wishbone byte selects
    input wire logic [31:0] wb_dat_i,      // Wishbone write data
    output logic [31:0] wb_dat_o,          // Wishbone read data
    output logic wb_ack_o,                 // Wishbone acknowledge
    input wire logic scl_i,                // Serial clock pin level
    input wire logic sda_i,                // Serial data pin level
    input wire logic rx_shift_valid_i,     // Receive shifter holds a whole byte
    input wire logic [7:0] rx_shift_data_i, // Receive shifter byte
    input wire logic addr_match_i,         // Slave address byte matched
    input wire logic addr_rw_i,            // Read bit of matched address byte
    input wire logic slave_data_i,         // Slave data byte received
    input wire logic tx_done_i,            // Data byte transmission finished
    input wire logic busy_i,               // Module busy on the bus
    output logic [7:0] tx_data_o,          // Byte for the transmit shifter
    output logic tx_load_o,                // Transmit shifter load pulse
    output logic module_on_o,              // Module enable
    output logic bus_active_o,             // Bus between start and stop
    output logic irq_o                     // Interrupt, active high level
);

    ibs_cond_if cond ();

    ibs_cond_det u_det (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .cond(cond)
    );

    // =========================================================================
    // Bus port decode
    logic req_w;
    logic wr_w;
    logic rd_w;
    logic sel0_w;
    logic wr_stat_w;
    logic rd_rx_w;
    logic wr_tx_w;
    logic wr_ctrl_w;
    logic wr_irq_clr_w;
    logic wr_irq_en_w;

    assign req_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_w = req_w && wb_we_i;
    assign rd_w = req_w && !wb_we_i;
    assign sel0_w = wb_sel_i[0];
    assign wr_stat_w = wr_w && sel0_w && (wb_adr_i == ibs_pkg::STAT_OFS);
    assign rd_rx_w = rd_w && (wb_adr_i == ibs_pkg::RXHOLD_OFS);
    assign wr_tx_w = wr_w && sel0_w && (wb_adr_i == ibs_pkg::TXHOLD_OFS);
    assign wr_ctrl_w = wr_w && sel0_w && (wb_adr_i == ibs_pkg::CTRL_OFS);
    assign wr_irq_clr_w = wr_w && sel0_w && (wb_adr_i == ibs_pkg::IRQ_CLR_OFS);
    assign wr_irq_en_w = wr_w && sel0_w && (wb_adr_i == ibs_pkg::IRQ_EN_OFS);

    // =========================================================================
    // State
    logic on_q;
    logic stop_last_q;
    logic start_last_q;
    logic rw_q;
    logic da_q;
    logic rx_full_q;
    logic tx_full_q;
    logic ovf_q;
    logic wcol_q;
    logic [7:0] rx_hold_q;
    logic [ibs_pkg::EV_NUM-1:0] irq_stat_q;
    logic [ibs_pkg::EV_NUM-1:0] irq_en_q;
    logic [ibs_pkg::EV_NUM-1:0] ev_w;
    logic rx_load_w;
    logic rx_ovf_w;
    logic tx_take_w;
    logic tx_coll_w;
    logic [7:0] stat_w;

    // A byte may enter the holding register in the cycle software empties it
    assign rx_load_w = rx_shift_valid_i && (!rx_full_q || rd_rx_w);
    assign rx_ovf_w = rx_shift_valid_i && rx_full_q && !rd_rx_w;
    // A write while a byte still waits or the bus is busy is dropped
    assign tx_coll_w = wr_tx_w && (busy_i || tx_full_q);
    assign tx_take_w = wr_tx_w && !tx_coll_w;

    // =========================================================================
    // Control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            on_q <= 1'b0;
        end else if (wr_ctrl_w) begin
            on_q <= wb_dat_i[ibs_pkg::ON_BIT];
        end
    end

    // =========================================================================
    // Last bus condition
    always_ff @(posedge clk_i) begin
        if (rst_i || !on_q) begin
            stop_last_q <= 1'b0;
            start_last_q <= 1'b0;
        end else if (cond.stop_seen) begin
            stop_last_q <= 1'b1;
            start_last_q <= 1'b0;
        end else if (cond.start_seen) begin
            stop_last_q <= 1'b0;
            start_last_q <= 1'b1;
        end
    end

    // =========================================================================
    // Slave address and data tracking
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rw_q <= 1'b0;
        end else if (addr_match_i) begin
            rw_q <= addr_rw_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            da_q <= 1'b0;
        end else if (addr_match_i) begin
            da_q <= 1'b0;
        end else if (slave_data_i) begin
            da_q <= 1'b1;
        end
    end

    // =========================================================================
    // Receive holding register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_hold_q <= ibs_pkg::BYTE_RST;
        end else if (rx_load_w) begin
            rx_hold_q <= rx_shift_data_i;
        end
    end

    // Setting wins over the read that empties it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_full_q <= 1'b0;
        end else if (rx_load_w) begin
            rx_full_q <= 1'b1;
        end else if (rd_rx_w) begin
            rx_full_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ovf_q <= 1'b0;
        end else if (rx_ovf_w) begin
            ovf_q <= 1'b1;
        end else if (wr_stat_w && !wb_dat_i[ibs_pkg::OVF_BIT]) begin
            ovf_q <= 1'b0;
        end
    end

    // =========================================================================
    // Transmit holding register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_data_o <= ibs_pkg::BYTE_RST;
            tx_load_o <= 1'b0;
        end else begin
            tx_load_o <= tx_take_w;
            if (tx_take_w) begin
                tx_data_o <= wb_dat_i[7:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_full_q <= 1'b0;
        end else if (tx_take_w) begin
            tx_full_q <= 1'b1;
        end else if (tx_done_i) begin
            tx_full_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wcol_q <= 1'b0;
        end else if (tx_coll_w) begin
            wcol_q <= 1'b1;
        end else if (wr_stat_w && !wb_dat_i[ibs_pkg::WCOL_BIT]) begin
            wcol_q <= 1'b0;
        end
    end

    // =========================================================================
    // Interrupt status, enable and output
    always_comb begin
        ev_w = '0;
        ev_w[ibs_pkg::EV_START] = cond.start_seen && on_q;
        ev_w[ibs_pkg::EV_STOP] = cond.stop_seen && on_q;
        ev_w[ibs_pkg::EV_RXFULL] = rx_load_w;
        ev_w[ibs_pkg::EV_OVF] = rx_ovf_w;
        ev_w[ibs_pkg::EV_WCOL] = tx_coll_w;
        ev_w[ibs_pkg::EV_TXDONE] = tx_done_i && tx_full_q;
    end

    // A fresh event beats a clear written in the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < ibs_pkg::EV_NUM; gi++) begin : g_irq
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    irq_stat_q[gi] <= 1'b0;
                end else if (ev_w[gi]) begin
                    irq_stat_q[gi] <= 1'b1;
                end else if (wr_irq_clr_w && wb_dat_i[gi]) begin
                    irq_stat_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_en_q <= ibs_pkg::IRQ_RST;
        end else if (wr_irq_en_w) begin
            irq_en_q <= wb_dat_i[ibs_pkg::EV_NUM-1:0];
        end
    end

    // One cycle behind the status so the output comes from a flip-flop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat_q & irq_en_q);
        end
    end

    // =========================================================================
    // Level outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            module_on_o <= 1'b0;
            bus_active_o <= 1'b0;
        end else begin
            module_on_o <= on_q;
            bus_active_o <= cond.bus_active;
        end
    end

    // =========================================================================
    // Status word and read path
    always_comb begin
        stat_w = ibs_pkg::STAT_RST;
        stat_w[ibs_pkg::TXFULL_BIT] = tx_full_q;
        stat_w[ibs_pkg::RXFULL_BIT] = rx_full_q;
        stat_w[ibs_pkg::RW_BIT] = rw_q;
        stat_w[ibs_pkg::START_BIT] = start_last_q;
        stat_w[ibs_pkg::STOP_BIT] = stop_last_q;
        stat_w[ibs_pkg::DA_BIT] = da_q;
        stat_w[ibs_pkg::OVF_BIT] = ovf_q;
        stat_w[ibs_pkg::WCOL_BIT] = wcol_q;
    end

    // Unmapped and write-only offsets are still acknowledged and read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req_w;
            wb_dat_o <= 32'h0000_0000;
            if (rd_w) begin
                case (wb_adr_i)
                    ibs_pkg::STAT_OFS: wb_dat_o <= {24'h00_0000, stat_w};
                    ibs_pkg::RXHOLD_OFS: wb_dat_o <= {24'h00_0000, rx_hold_q};
                    ibs_pkg::TXHOLD_OFS: wb_dat_o <= {24'h00_0000, tx_data_o};
                    ibs_pkg::CTRL_OFS: wb_dat_o <= {31'h0000_0000, on_q};
                    ibs_pkg::IRQ_STAT_OFS: wb_dat_o <= {26'h000_0000, irq_stat_q};
                    ibs_pkg::IRQ_EN_OFS: wb_dat_o <= {26'h000_0000, irq_en_q};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule : ibs_flags

// file: sim/ibs_bus_model.sv
// Far side of the two-wire bus plus the shifter events it causes.
// Assumes pull-ups on both lines: idle level is high; byte lines go stale when not valid.
`timescale 1ns/1ps
module ibs_bus_model (
    input wire logic clk_i,         // Clock
    output logic scl_o,             // Serial clock line
    output logic sda_o,             // Serial data line
    output logic rx_valid_o,        // Received byte pulse
    output logic [7:0] rx_data_o,   // Received byte
    output logic match_o,           // Address match pulse
    output logic rw_o,              // Read bit of address
    output logic sdata_o,           // Slave data byte pulse
    output logic done_o,            // Transmission finished pulse
    output logic busy_o             // Module busy level
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
        rx_valid_o = 1'b0;
        rx_data_o = 8'h00;
        match_o = 1'b0;
        rw_o = 1'b0;
        sdata_o = 1'b0;
        done_o = 1'b0;
        busy_o = 1'b0;
    end

    // =========================================================================
    // Line levels, each held long enough to pass the synchroniser
    task automatic step(input logic c, input logic d);
        @(posedge clk_i);
        scl_o <= c;
        sda_o <= d;
        repeat (7) @(posedge clk_i);
    endtask : step
    // Works from idle and as a repeated start from a low clock
    task automatic start_c();
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask : start_c
    task automatic stop_c();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask : stop_c

    // =========================================================================
    // Event pulses; qualifiers turn stale once the pulse ends
    task automatic rx_byte(input logic [7:0] b);
        @(posedge clk_i);
        rx_valid_o <= 1'b1;
        rx_data_o <= b;
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        rx_data_o <= ~b;
    endtask : rx_byte
    task automatic addr_ev(input logic r);
        @(posedge clk_i);
        match_o <= 1'b1;
        rw_o <= r;
        @(posedge clk_i);
        match_o <= 1'b0;
        rw_o <= ~r;
    endtask : addr_ev
    task automatic pulse_ev(input logic k);
        @(posedge clk_i);
        sdata_o <= !k;
        done_o <= k;
        @(posedge clk_i);
        sdata_o <= 1'b0;
        done_o <= 1'b0;
    endtask : pulse_ev
    task automatic set_busy(input logic b);
        @(posedge clk_i);
        busy_o <= b;
    endtask : set_busy
endmodule : ibs_bus_model

// file: sim/ibs_flags_asserts.sv
// Concurrent checks on the top ports of the bus state flag block.
// Assumes one clock and a classic Wishbone master that holds each request until ack.
`timescale 1ns/1ps
module ibs_flags_asserts (
    input wire logic clk_i,             // Clock
    input wire logic rst_i,             // Synchronous reset
    input wire logic wb_cyc_i,          // Cycle
    input wire logic wb_stb_i,          // Strobe
    input wire logic wb_we_i,           // Write enable
    input wire logic [7:0] wb_adr_i,    // Byte address
    input wire logic [3:0] wb_sel_i,    // Byte selects
    input wire logic [31:0] wb_dat_i,   // Write data
    input wire logic [31:0] wb_dat_o,   // Read data
    input wire logic wb_ack_o,          // Acknowledge
    input wire logic busy_i,            // Module busy
    input wire logic [7:0] tx_data_o,   // Transmit byte
    input wire logic tx_load_o,         // Transmit load pulse
    input wire logic module_on_o        // Module enable
);
    // =========================================================================
    // Shared conditions
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic req_w;
    logic req_stat_r;
    assign req_w = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
    assign req_stat_r = wb_cyc_i && wb_stb_i && !wb_we_i && (wb_adr_i == ibs_pkg::STAT_OFS);

    // =========================================================================
    // Register port handshake
    ack_after_req_a: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    rdata_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
    upper_bits_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper read bits set");

    // =========================================================================
    // Transmit holding register
    txload_cause_a: assert property (tx_load_o |-> $past(req_w && wb_adr_i == ibs_pkg::TXHOLD_OFS)
        && tx_data_o == $past(wb_dat_i[7:0])) else $error("load pulse without matching write");
    txdata_stable_a: assert property ($changed(tx_data_o) |-> $past(req_w && wb_adr_i == ibs_pkg::TXHOLD_OFS))
        else $error("transmit byte changed without write");
    busy_drop_a: assert property ((req_w && !wb_ack_o && wb_adr_i == ibs_pkg::TXHOLD_OFS && busy_i)
        |=> !tx_load_o [*2]) else $error("write while busy was loaded");

    // =========================================================================
    // Enable and start/stop flags
    ctrl_enable_a: assert property ((req_w && !wb_ack_o && wb_adr_i == ibs_pkg::CTRL_OFS)
        |-> ##2 (module_on_o == $past(wb_dat_i[ibs_pkg::ON_BIT], 2))) else $error("enable not following write");
    stat_off_a: assert property ((wb_ack_o && !module_on_o && $past(req_stat_r))
        |-> !wb_dat_o[ibs_pkg::START_BIT] && !wb_dat_o[ibs_pkg::STOP_BIT]) else $error("start or stop while off");
    start_stop_excl_a: assert property ((wb_ack_o && $past(req_stat_r))
        |-> !(wb_dat_o[ibs_pkg::START_BIT] && wb_dat_o[ibs_pkg::STOP_BIT])) else $error("start and stop both set");
endmodule : ibs_flags_asserts

bind ibs_flags ibs_flags_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .busy_i(busy_i), .tx_data_o(tx_data_o), .tx_load_o(tx_load_o), .module_on_o(module_on_o));

// file: sim/ibs_flags_tb_top.sv
// Self-checking bench for the bus state flag block and its register port.
// Assumes the bus model above drives the pins and shifter events.
`timescale 1ns/1ps
module ibs_flags_tb_top;
    localparam logic [7:0] ST = ibs_pkg::STAT_OFS;
    localparam logic [7:0] RX = ibs_pkg::RXHOLD_OFS;
    localparam logic [7:0] TX = ibs_pkg::TXHOLD_OFS;
    localparam logic [7:0] CT = ibs_pkg::CTRL_OFS;
    localparam logic [31:0] RXM = 32'h1 << ibs_pkg::EV_RXFULL;
    logic clk_i, rst_i, cyc, stb, we, scl, sda, rxv, mt, rw, sd, dn, bz, r;
    logic [7:0] adr, rxd, b1, b2;
    logic [3:0] sel;
    logic [31:0] wdat, q, seed;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, tx_load_o, module_on_o, bus_active_o, irq_o;
    logic [7:0] tx_data_o;
    int miscompares = 0;
    int checked = 0;

    ibs_flags DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl), .sda_i(sda),
        .rx_shift_valid_i(rxv), .rx_shift_data_i(rxd), .addr_match_i(mt), .addr_rw_i(rw), .slave_data_i(sd),
        .tx_done_i(dn), .busy_i(bz), .tx_data_o(tx_data_o), .tx_load_o(tx_load_o), .module_on_o(module_on_o),
        .bus_active_o(bus_active_o), .irq_o(irq_o));
    ibs_bus_model u_bus (.clk_i(clk_i), .scl_o(scl), .sda_o(sda), .rx_valid_o(rxv), .rx_data_o(rxd),
        .match_o(mt), .rw_o(rw), .sdata_o(sd), .done_o(dn), .busy_o(bz));

    // =========================================================================
    // Expectations and stimulus helpers
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    function automatic logic [31:0] sf(input logic tf, rf, w, s, p, da, ov, wc);
        sf = 32'h0;
        sf[ibs_pkg::TXFULL_BIT] = tf;
        sf[ibs_pkg::RXFULL_BIT] = rf;
        sf[ibs_pkg::RW_BIT] = w;
        sf[ibs_pkg::START_BIT] = s;
        sf[ibs_pkg::STOP_BIT] = p;
        sf[ibs_pkg::DA_BIT] = da;
        sf[ibs_pkg::OVF_BIT] = ov;
        sf[ibs_pkg::WCOL_BIT] = wc;
    endfunction : sf
    task automatic end_sim();
        if (miscompares == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            $display("[ERR] %0t got %h expected %h", $time, g, e);
            miscompares++;
        end
    endtask : chk
    // Ack is sampled at the rising edge it stands at; data is taken and the request released there
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            $display("[ERR] %0t no acknowledge", $time);
            miscompares++;
            end_sim();
        end else begin
            q = wb_dat_o;
            cyc <= 1'b0;
            stb <= 1'b0;
            we <= 1'b0;
        end
    endtask : wb
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd_chk
    task automatic sig_chk(input logic [7:0] a, input logic w, input logic [31:0] d, input logic e);
        wb(w, a, d);
        repeat (3) @(negedge clk_i);
        chk({31'h0, irq_o}, {31'h0, e});
    endtask : sig_chk

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // =========================================================================
    // Main sequence
    initial begin
        rst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'hF;
        wdat = 32'h0;
        seed = 32'hE34CBC19;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(ST, 32'h0);
        rd_chk(CT, 32'h0);
        rd_chk(ibs_pkg::IRQ_STAT_OFS, 32'h0);
        wb(1'b1, 8'h1C, 32'hFF);
        rd_chk(8'h1C, 32'h0);
        wb(1'b1, CT, 32'h1);
        seed = xs(seed);
        r = seed[0];
        b2 = seed[23:16];
        b1 = b2 ^ 8'h5A;
        u_bus.start_c();
        rd_chk(ST, sf(0, 0, 0, 1, 0, 0, 0, 0));
        chk({31'h0, bus_active_o}, 32'h1);
        u_bus.stop_c();
        rd_chk(ST, sf(0, 0, 0, 0, 1, 0, 0, 0));
        chk({31'h0, bus_active_o}, 32'h0);
        u_bus.start_c();
        rd_chk(ST, sf(0, 0, 0, 1, 0, 0, 0, 0));
        u_bus.addr_ev(r);
        rd_chk(ST, sf(0, 0, r, 1, 0, 0, 0, 0));
        u_bus.pulse_ev(1'b0);
        rd_chk(ST, sf(0, 0, r, 1, 0, 1, 0, 0));
        u_bus.addr_ev(~r);
        u_bus.start_c();
        rd_chk(ST, sf(0, 0, ~r, 1, 0, 0, 0, 0));
        u_bus.rx_byte(b1);
        rd_chk(ST, sf(0, 1, ~r, 1, 0, 0, 0, 0));
        u_bus.rx_byte(b2);
        rd_chk(ST, sf(0, 1, ~r, 1, 0, 0, 1, 0));
        rd_chk(RX, {24'h0, b1});
        rd_chk(ST, sf(0, 0, ~r, 1, 0, 0, 1, 0));
        wb(1'b1, ST, 32'h80);
        rd_chk(ST, sf(0, 0, ~r, 1, 0, 0, 0, 0));
        wb(1'b1, TX, {24'h0, b2});
        rd_chk(ST, sf(1, 0, ~r, 1, 0, 0, 0, 0));
        wb(1'b1, TX, {24'h0, b1});
        rd_chk(ST, sf(1, 0, ~r, 1, 0, 0, 0, 1));
        chk({24'h0, tx_data_o}, {24'h0, b2});
        u_bus.pulse_ev(1'b1);
        wb(1'b1, ST, 32'h40);
        rd_chk(ST, sf(0, 0, ~r, 1, 0, 0, 0, 0));
        u_bus.set_busy(1'b1);
        wb(1'b1, TX, {24'h0, b1});
        u_bus.set_busy(1'b0);
        rd_chk(ST, sf(0, 0, ~r, 1, 0, 0, 0, 1));
        wb(1'b1, ST, 32'h0);
        rd_chk(ibs_pkg::IRQ_STAT_OFS, 32'h3F);
        wb(1'b1, ibs_pkg::IRQ_CLR_OFS, 32'h3F);
        wb(1'b1, ibs_pkg::IRQ_EN_OFS, RXM);
        u_bus.rx_byte(b1);
        rd_chk(ibs_pkg::IRQ_STAT_OFS, RXM);
        sig_chk(ibs_pkg::IRQ_EN_OFS, 1'b1, 32'h0, 1'b0);
        sig_chk(ibs_pkg::IRQ_EN_OFS, 1'b1, RXM, 1'b1);
        sig_chk(ibs_pkg::IRQ_CLR_OFS, 1'b1, RXM, 1'b0);
        rd_chk(RX, {24'h0, b1});
        u_bus.stop_c();
        rd_chk(ST, sf(0, 0, ~r, 0, 1, 0, 0, 0));
        wb(1'b1, CT, 32'h0);
        u_bus.start_c();
        rd_chk(ST, sf(0, 0, ~r, 0, 0, 0, 0, 0));
        chk({31'h0, bus_active_o}, 32'h1);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            u_bus.rx_byte(seed[7:0]);
            rd_chk(RX, {24'h0, seed[7:0]});
            wb(1'b1, TX, {24'h0, seed[15:8]});
            chk({24'h0, tx_data_o}, {24'h0, seed[15:8]});
            u_bus.pulse_ev(1'b1);
            rd_chk(ST, sf(0, 0, ~r, 0, 0, 0, 0, 0));
        end
        end_sim();
    end
endmodule : ibs_flags_tb_top
